// [smbus_slave_pkg.sv]
// Shared constants, types and states of the SMBus slave register access block
package smbus_slave_pkg;

  localparam logic [6:0] SLAVE_ADDR = 7'h2E;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic DIR_READ = 1'h1;
  localparam logic [1:0] PIN_SEL_ALERT = 2'h2;

  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int BUS_TIMEOUT_MS = 35;
  localparam int BUS_TIMEOUT_CYCLES = (SYS_CLK_HZ / 1000) * BUS_TIMEOUT_MS;
  localparam int TIMEOUT_CNT_W = 19;

  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic [1:0] BYTE_CNT_ZERO = 2'h0;
  localparam logic [1:0] BYTE_CNT_ONE = 2'h1;
  localparam logic [1:0] BYTE_CNT_MAX = 2'h2;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // Sampled line levels and the conditions found on them
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_edge;
    logic start;
    logic stop;
  } line_events_type;

  // Port into the device's register file
  typedef struct packed {
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] wdata;
    logic wr;
  } reg_access_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_WR_BYTE = 3'h3,
    ST_WR_ACK = 3'h4,
    ST_RD_BYTE = 3'h5,
    ST_RD_ACK = 3'h6,
    ST_IGNORE = 3'h7
  } smb_state_type;

endpackage : smbus_slave_pkg

// [smbus_line_sampler.sv]
// Synchroniser and condition detector for the SCL and SDA lines
module smbus_line_sampler
  import smbus_slave_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_scl,
  input wire logic i_sda,
  output line_events_type o_ev
);

  logic [1:0] meta_d;
  logic [1:0] meta_q;
  logic [1:0] sync_d;
  logic [1:0] sync_q;
  logic [1:0] prev_d;
  logic [1:0] prev_q;

  always_comb begin
    meta_d = {i_scl, i_sda};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Idle bus is high on both lines, so reset to high avoids a false start
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else if (i_clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  always_comb begin
    o_ev.scl = sync_q[1];
    o_ev.sda = sync_q[0];
    o_ev.scl_rise = sync_q[1] & ~prev_q[1];
    o_ev.scl_fall = ~sync_q[1] & prev_q[1];
    o_ev.sda_edge = sync_q[0] ^ prev_q[0];
    o_ev.start = sync_q[1] & prev_q[1] & ~sync_q[0] & prev_q[0];
    o_ev.stop = sync_q[1] & prev_q[1] & sync_q[0] & ~prev_q[0];
  end

endmodule : smbus_line_sampler

// [smbus_slave_register_access.sv]
// SMBus slave: address match, pointer and register access, alert response and bus timeout
module smbus_slave_register_access
  import smbus_slave_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output reg_access_type o_reg,
  input wire logic [BYTE_W-1:0] i_reg_rd_data,
  input wire logic i_alert_condition,
  input wire logic [1:0] i_pin_function_sel,
  input wire logic i_bus_timeout_disable,
  output logic o_alert_out,
  output logic o_alert_oe
);

  line_events_type ev;

  smb_state_type state_d;
  smb_state_type state_q;
  logic [BIT_CNT_W-1:0] bit_cnt_d;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [1:0] byte_cnt_d;
  logic [1:0] byte_cnt_q;
  logic [BYTE_W-1:0] shift_d;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] tx_d;
  logic [BYTE_W-1:0] tx_q;
  logic rd_dir_d;
  logic rd_dir_q;
  logic ara_d;
  logic ara_q;
  logic [BYTE_W-1:0] ptr_d;
  logic [BYTE_W-1:0] ptr_q;
  logic [BYTE_W-1:0] wdata_d;
  logic [BYTE_W-1:0] wdata_q;
  logic wr_d;
  logic wr_q;
  logic sda_oe_d;
  logic sda_oe_q;
  logic alert_d;
  logic alert_q;
  logic ara_done;
  logic alert_active;
  logic timeout;
  logic [TIMEOUT_CNT_W-1:0] to_cnt_d;
  logic [TIMEOUT_CNT_W-1:0] to_cnt_q;

  localparam logic [TIMEOUT_CNT_W-1:0] TIMEOUT_LAST = TIMEOUT_CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [TIMEOUT_CNT_W-1:0] TO_CNT_ONE = 19'h00001;
  localparam logic [TIMEOUT_CNT_W-1:0] TO_CNT_ZERO = 19'h00000;

  // Shift one sampled bit in, most significant bit first
  function automatic logic [BYTE_W-1:0] shift_bit_in(input logic [BYTE_W-1:0] cur, input logic bit_in);
    shift_bit_in = {cur[BYTE_W-2:0], bit_in};
  endfunction : shift_bit_in

  smbus_line_sampler u_sampler (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_ev(ev)
  );

  // The alert may only be seen, and only answered, while the pin serves as alert
  assign alert_active = alert_q & (i_pin_function_sel == PIN_SEL_ALERT);

  // Bus timeout: any line edge restarts the count, so a slow but live master is not cut off
  always_comb begin
    to_cnt_d = to_cnt_q;
    if (state_q == ST_IDLE || ev.scl_rise || ev.scl_fall || ev.sda_edge || i_bus_timeout_disable) begin
      to_cnt_d = TO_CNT_ZERO;
    end else if (to_cnt_q != TIMEOUT_LAST) begin
      to_cnt_d = to_cnt_q + TO_CNT_ONE;
    end
  end

  assign timeout = (to_cnt_q == TIMEOUT_LAST) && (state_q != ST_IDLE);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      to_cnt_q <= TO_CNT_ZERO;
    end else if (i_clk_en) begin
      to_cnt_q <= to_cnt_d;
    end
  end

  // Protocol engine
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    rd_dir_d = rd_dir_q;
    ara_d = ara_q;
    ptr_d = ptr_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    ara_done = 1'b0;
    if (ev.stop || timeout) begin
      state_d = ST_IDLE;
    end else if (ev.start) begin
      state_d = ST_ADDR;
      bit_cnt_d = BIT_CNT_ZERO;
      byte_cnt_d = BYTE_CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          state_d = state_q;
        end
        ST_ADDR: begin
          if (ev.scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
            shift_d = shift_bit_in(shift_q, ev.sda);
            bit_cnt_d = bit_cnt_q + BIT_CNT_ONE;
          end
          if (ev.scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
            bit_cnt_d = BIT_CNT_ZERO;
            rd_dir_d = (shift_q[0] == DIR_READ);
            if (shift_q[BYTE_W-1:1] == SLAVE_ADDR) begin
              state_d = ST_ADDR_ACK;
              ara_d = 1'b0;
            end else if (shift_q[BYTE_W-1:1] == ALERT_RESP_ADDR && shift_q[0] == DIR_READ && alert_active) begin
              state_d = ST_ADDR_ACK;
              ara_d = 1'b1;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            if (rd_dir_q) begin
              // Own address in the upper seven bits for the alert answer
              tx_d = ara_q ? {SLAVE_ADDR, 1'b0} : i_reg_rd_data;
              state_d = ST_RD_BYTE;
            end else begin
              state_d = ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (ev.scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
            shift_d = shift_bit_in(shift_q, ev.sda);
            bit_cnt_d = bit_cnt_q + BIT_CNT_ONE;
          end
          if (ev.scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
            bit_cnt_d = BIT_CNT_ZERO;
            byte_cnt_d = byte_cnt_q + BYTE_CNT_ONE;
            if (byte_cnt_q == BYTE_CNT_ZERO) begin
              ptr_d = shift_q;
              state_d = ST_WR_ACK;
            end else if (byte_cnt_q == BYTE_CNT_ONE) begin
              wdata_d = shift_q;
              wr_d = 1'b1;
              state_d = ST_WR_ACK;
            end else begin
              // A third byte is refused with no acknowledge
              state_d = ST_IGNORE;
            end
          end
        end
        ST_WR_ACK: begin
          if (ev.scl_fall) begin
            state_d = (byte_cnt_q == BYTE_CNT_MAX) ? ST_IGNORE : ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (ev.scl_rise) begin
            if (tx_q[BYTE_W-1] && !ev.sda) begin
              state_d = ST_IGNORE;
            end else begin
              bit_cnt_d = bit_cnt_q + BIT_CNT_ONE;
            end
          end
          if (ev.scl_fall) begin
            if (bit_cnt_q == BITS_PER_BYTE) begin
              bit_cnt_d = BIT_CNT_ZERO;
              ara_done = ara_q;
              state_d = ST_RD_ACK;
            end else begin
              tx_d = {tx_q[BYTE_W-2:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          // Exactly one byte per read, whatever the master answers
          if (ev.scl_rise) begin
            state_d = ST_IGNORE;
          end
        end
      endcase
    end
    sda_oe_d = (state_d == ST_ADDR_ACK) || (state_d == ST_WR_ACK) ||
               ((state_d == ST_RD_BYTE) && !tx_d[BYTE_W-1]);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= BIT_CNT_ZERO;
      byte_cnt_q <= BYTE_CNT_ZERO;
      shift_q <= BYTE_ZERO;
      tx_q <= BYTE_ZERO;
      rd_dir_q <= 1'b0;
      ara_q <= 1'b0;
      ptr_q <= BYTE_ZERO;
      wdata_q <= BYTE_ZERO;
      wr_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      rd_dir_q <= rd_dir_d;
      ara_q <= ara_d;
      ptr_q <= ptr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // Alert: a live condition beats the clear from a completed alert answer
  always_comb begin
    alert_d = i_alert_condition | (alert_q & ~ara_done);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      alert_q <= 1'b0;
    end else if (i_clk_en) begin
      alert_q <= alert_d;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_q;
  assign o_alert_out = 1'b0;
  assign o_alert_oe = alert_active;
  assign o_reg.ptr = ptr_q;
  assign o_reg.wdata = wdata_q;
  assign o_reg.wr = wr_q;

endmodule : smbus_slave_register_access

// [smbus_slave_chk.sv]
// Port-level assertions for the SMBus slave
module smbus_slave_chk
  import smbus_slave_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire reg_access_type o_reg,
  input wire logic i_alert_condition,
  input wire logic [1:0] i_pin_function_sel,
  input wire logic i_bus_timeout_disable,
  input wire logic o_alert_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int quiet_q, quiet_d;
  logic [1:0] lines_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Saturates just past the limit so the antecedent fires once per stall
  always_comb begin
    quiet_d = (quiet_q > TIMEOUT_CYCLES + 8) ? quiet_q : quiet_q + 1;
    if (i_reset || lines_q != {i_scl, i_sda}) begin
      quiet_d = 0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    quiet_q <= quiet_d;
    lines_q <= {i_scl, i_sda};
  end
  sequence ack_soon;
    ##[0:2] o_sda_oe;
  endsequence
  a_ack_width: assert property ($rose(o_sda_oe) |-> o_sda_oe [*5])
    else $error("SDA pull too short");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("SDA moved with SCL high");
  a_ptr_on_ack: assert property ($changed(o_reg.ptr) |-> ack_soon)
    else $error("Pointer moved unacknowledged");
  a_wr_pulse: assert property (o_reg.wr |=> !o_reg.wr)
    else $error("Write pulse too long");
  a_wr_acked: assert property (o_reg.wr |-> ack_soon)
    else $error("Write without acknowledge");
  a_alert_sets: assert property (i_alert_condition && i_pin_function_sel == PIN_SEL_ALERT |=> o_alert_oe)
    else $error("Alert dropped early");
  a_alert_pin: assert property (o_alert_oe |-> i_pin_function_sel == PIN_SEL_ALERT)
    else $error("Alert on wrong function");
  a_bus_timeout: assert property (quiet_q == TIMEOUT_CYCLES + 8 && !i_bus_timeout_disable |-> !o_sda_oe)
    else $error("SDA held past timeout");
endmodule : smbus_slave_chk

bind smbus_slave_register_access smbus_slave_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (.i_sys_clk, .i_reset,
  .i_scl, .i_sda, .o_sda_oe, .o_reg, .i_alert_condition, .i_pin_function_sel, .i_bus_timeout_disable, .o_alert_oe);

// [smb_master_model.sv]
// Bus master model: drives SCL and its share of SDA
module smb_master_model (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Also a repeated start: waits out the slave's acknowledge before releasing SDA
  task automatic start();
    #230 o_sda = 1'b1;
    #300 o_scl = 1'b1;
    #150 o_sda = 1'b0;
    #150 o_scl = 1'b0;
  endtask : start
  task automatic bit_clk(input logic b, output logic s);
    #250 o_sda = b;
    #300 o_scl = 1'b1;
    #120 s = i_sda;
    #130 o_scl = 1'b0;
  endtask : bit_clk
  // Reads pass FF; the ninth bit is always released, whatever d holds: no acknowledge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_clk(d[i], q[i]);
    end
    bit_clk(1'b1, ack);
  endtask : xfer
  task automatic stop();
    #250 o_sda = 1'b0;
    #300 o_scl = 1'b1;
    #150 o_sda = 1'b1;
    #300;
  endtask : stop
endmodule : smb_master_model

// [tb_top.sv]
// Self-checking bench for the SMBus slave
module tb_top;
  import smbus_slave_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO_CYC = 200;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_alert_condition = 1'b0, i_bus_timeout_disable = 1'b0;
  logic [1:0] i_pin_function_sel = 2'h2;
  logic rival_low = 1'b0, i_scl, m_sda, i_sda, o_sda_out, o_sda_oe, o_alert_oe, o_alert_out, ack;
  logic [7:0] rd_q, wr_seen, i_reg_rd_data;
  reg_access_type o_reg;
  int error_cnt = 0, comparisons = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  // Pulled-up wire; rival_low stands for a slave with a lower address
  assign i_sda = m_sda & ~(o_sda_oe & ~o_sda_out) & ~rival_low;
  assign i_reg_rd_data = ~o_reg.ptr;
  smbus_slave_register_access #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (.i_sys_clk, .i_reset, .i_clk_en, .i_scl, .i_sda,
    .o_sda_out, .o_sda_oe, .o_reg, .i_reg_rd_data, .i_alert_condition, .i_pin_function_sel, .i_bus_timeout_disable,
    .o_alert_out, .o_alert_oe);
  smb_master_model m (.o_scl(i_scl), .o_sda(m_sda), .i_sda);
  always @(posedge i_sys_clk) begin
    if (o_reg.wr === 1'b1) begin
      wr_seen = o_reg.wdata;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Errors %0d in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic send(input logic [7:0] d, input logic exp);
    m.xfer(d, rd_q, ack);
    check("acknowledge", ack, exp);
  endtask : send
  task automatic s_write();
    for (int k = 0; k < 2; k++) begin
      m.start();
      send(8'h5E + 8'(k), 1'b1);
      m.stop();
    end
    m.start();
    send(8'h5C, 1'b0);
    send(8'h12, 1'b0);
    send(8'hA5, 1'b0);
    send(8'h77, 1'b1);
    m.stop();
    check("pointer", o_reg.ptr, 8'h12);
    check("write data", wr_seen, 8'hA5);
  endtask : s_write
  task automatic s_read();
    m.start();
    send(8'h5C, 1'b0);
    send(8'h33, 1'b0);
    for (int k = 0; k < 2; k++) begin
      m.start();
      send(8'h5D, 1'b0);
      m.xfer(8'hFF, rd_q, ack);
      m.stop();
      check("read data", rd_q, 8'hCC);
    end
  endtask : s_read
  task automatic ara(input logic rival, input logic [7:0] exp_data, input logic exp_alert);
    m.start();
    send(8'h19, 1'b0);
    rival_low = rival;
    m.xfer(8'hFF, rd_q, ack);
    rival_low = 1'b0;
    m.stop();
    check("alert reply", rd_q, exp_data);
    check("alert pin", o_alert_oe, exp_alert);
    check("alert level", o_alert_out, 1'b0);
    check("data level", o_sda_out, 1'b0);
  endtask : ara
  task automatic s_alert();
    @(negedge i_sys_clk);
    i_pin_function_sel = 2'h1;
    i_alert_condition = 1'b1;
    m.start();
    send(8'h19, 1'b1);
    m.stop();
    check("alert off", o_alert_oe, 1'b0);
    @(negedge i_sys_clk);
    i_pin_function_sel = 2'h2;
    repeat (2) @(negedge i_sys_clk);
    check("alert on", o_alert_oe, 1'b1);
    ara(1'b0, 8'h5C, 1'b1);
    @(negedge i_sys_clk);
    i_alert_condition = 1'b0;
    ara(1'b1, 8'h00, 1'b1);
    ara(1'b0, 8'h5C, 1'b0);
  endtask : s_alert
  // A frozen block must neither answer nor move its pointer
  task automatic s_freeze();
    @(negedge i_sys_clk);
    i_clk_en = 1'b0;
    m.start();
    send(8'h5C, 1'b1);
    m.stop();
    check("pointer frozen", o_reg.ptr, 8'h33);
    @(negedge i_sys_clk);
    i_clk_en = 1'b1;
    repeat (4) @(negedge i_sys_clk);
  endtask : s_freeze
  task automatic s_timeout(input logic dis);
    @(negedge i_sys_clk);
    i_bus_timeout_disable = dis;
    m.start();
    send(8'h5C, 1'b0);
    repeat (TO_CYC + 100) @(negedge i_sys_clk);
    send(8'h44, ~dis);
    m.stop();
    check("pointer after stall", o_reg.ptr, dis ? 8'h44 : 8'h33);
  endtask : s_timeout
  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    s_write();
    s_read();
    s_alert();
    s_freeze();
    s_timeout(1'b0);
    s_timeout(1'b1);
    stop_test();
  end
  initial begin
    #1ms;
    error_cnt++;
    stop_test();
  end
endmodule : tb_top
